// File: verilog/pfm_top.v
// pfm_top.v: pulse frequency modulator with a classic wishbone slave.
// assumes the wishbone master runs on CLK; the clock option is a static
// strap that selects the counting rate as CLK divided by 2**option.
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "pfm_regs.vh"

module pfm_top #(
  parameter PERIOD_W = 16,
  parameter WIDTH_W  = 8
) (
  // clock and reset
  input  wire        CLK,
  input  wire        NRST,
  // wishbone slave
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [3:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  // hardware option for the counting clock
  input  wire [1:0]  FREQ_MOD_CLOCK_OPTION,
  // modulated output
  output reg         FREQ_MOD_OUT
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [31:0]         freq_mod_setting_r;
  reg  [31:0]         freq_mod_setting_nxt;
  reg                 freq_mod_enable_bit_r;
  reg                 freq_mod_enable_bit_nxt;
  reg                 pend_r;
  reg                 pend_nxt;
  reg  [PERIOD_W-1:0] per_rld_r;
  reg  [PERIOD_W-1:0] per_rld_nxt;
  reg  [WIDTH_W-1:0]  wid_rld_r;
  reg  [WIDTH_W-1:0]  wid_rld_nxt;
  reg  [PERIOD_W-1:0] per_cmt_r;
  reg  [PERIOD_W-1:0] per_cmt_nxt;
  reg  [WIDTH_W-1:0]  wid_cmt_r;
  reg  [WIDTH_W-1:0]  wid_cmt_nxt;
  reg                 active_r;
  reg  [7:0]          pre_cnt_r;
  reg  [7:0]          pre_cnt_nxt;
  reg                 out_nxt;
  reg  [31:0]         rdata_nxt;
  reg                 ack_nxt;
  wire                bus_req;
  wire                wr_set;
  wire                wr_ctl;
  wire                width_byte_wr;
  wire                tick;
  wire                start;
  wire                reload;
  wire                load;
  wire [PERIOD_W-1:0] per_cnt;
  wire [WIDTH_W-1:0]  wid_cnt;
  wire                per_zero;
  wire                wid_zero;
  wire                invert_output_flag;
  wire [PERIOD_W-1:0] per_load_val;
  wire [WIDTH_W-1:0]  wid_load_val;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // merge write data into a word under byte enables
  function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  sel;
    integer      i;
    begin
      merge_bytes = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // decode a register hit for one offset
  function addr_hit;
    input [3:0] adr;
    input [3:0] ofs;
    begin
      addr_hit = (adr == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // wishbone decode

  // one request per ack: ack drops the cycle after it was given
  assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_set  = bus_req && WB_WE_I &&
                   addr_hit(WB_ADR_I, `PFM_SETTING_OFS);
  assign wr_ctl  = bus_req && WB_WE_I &&
                   addr_hit(WB_ADR_I, `PFM_CONTROL_OFS);

  assign width_byte_wr = wr_set && WB_SEL_I[`PFM_WIDTH_BYTE];

  assign invert_output_flag = freq_mod_setting_r[`PFM_INV_BIT];

  ////////////////////////////////////////////////////////////////////////
  // setting register and enable

  always @* begin
    freq_mod_setting_nxt = freq_mod_setting_r;
    if (wr_set) begin
      freq_mod_setting_nxt = merge_bytes(freq_mod_setting_r, WB_DAT_I,
                                         WB_SEL_I) & `PFM_SETTING_MASK;
    end
  end

  always @* begin
    freq_mod_enable_bit_nxt = freq_mod_enable_bit_r;
    if (wr_ctl && WB_SEL_I[0]) begin
      freq_mod_enable_bit_nxt = WB_DAT_I[`PFM_ENABLE_BIT];
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      freq_mod_setting_r    <= `PFM_SETTING_RST;
      freq_mod_enable_bit_r <= 1'b0;
    end else begin
      freq_mod_setting_r    <= freq_mod_setting_nxt;
      freq_mod_enable_bit_r <= freq_mod_enable_bit_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // committed values
  // byte writes land in the setting register at once, so readback shows
  // them, but the counters only see a width and period once the width
  // byte has been written; a half-written period never reaches them,
  // neither at the next reload nor when the block leaves standby

  always @* begin
    per_cmt_nxt = per_cmt_r;
    wid_cmt_nxt = wid_cmt_r;
    if (width_byte_wr) begin
      per_cmt_nxt = freq_mod_setting_nxt[`PFM_PERIOD_LSB +: PERIOD_W];
      wid_cmt_nxt = freq_mod_setting_nxt[`PFM_WIDTH_LSB +: WIDTH_W];
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      per_cmt_r <= {PERIOD_W{1'b0}};
      wid_cmt_r <= {WIDTH_W{1'b0}};
    end else begin
      per_cmt_r <= per_cmt_nxt;
      wid_cmt_r <= wid_cmt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reload registers
  // the pending flag holds a committed update until the period wraps, so
  // a running cycle never mixes old and new values

  always @* begin
    pend_nxt    = pend_r;
    per_rld_nxt = per_rld_r;
    wid_rld_nxt = wid_rld_r;
    if (start || reload) begin
      pend_nxt    = 1'b0;
      per_rld_nxt = per_load_val;
      wid_rld_nxt = wid_load_val;
    end
    // a commit in the same cycle as a reload is kept, not lost
    if (width_byte_wr) begin
      pend_nxt = 1'b1;
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pend_r    <= 1'b0;
      per_rld_r <= {PERIOD_W{1'b0}};
      wid_rld_r <= {WIDTH_W{1'b0}};
    end else begin
      pend_r    <= pend_nxt;
      per_rld_r <= per_rld_nxt;
      wid_rld_r <= wid_rld_nxt;
    end
  end

  // a pending update is taken from the committed copy at the reload
  assign per_load_val = (pend_r || start) ? per_cmt_r : per_rld_r;
  assign wid_load_val = (pend_r || start) ? wid_cmt_r : wid_rld_r;

  ////////////////////////////////////////////////////////////////////////
  // counting clock
  // the input clock is a tick at CLK/2**option; the prescaler is held
  // cleared in standby so the gated clock restarts from a known phase

  always @* begin
    pre_cnt_nxt = pre_cnt_r + 8'h01;
    if (!active_r || tick) begin
      pre_cnt_nxt = 8'h00;
    end
  end

  assign tick = active_r &&
                (pre_cnt_r == ((8'h01 << FREQ_MOD_CLOCK_OPTION) - 8'h01));

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pre_cnt_r <= 8'h00;
      active_r  <= 1'b0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
      active_r  <= freq_mod_enable_bit_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counters

  assign start  = freq_mod_enable_bit_r && !active_r;
  assign reload = tick && (per_cnt <= {{(PERIOD_W-1){1'b0}}, 1'b1});
  assign load   = start || reload;

  pfm_down_counter #(
    .W (PERIOD_W)
  ) u_period (
    .clk      (CLK),
    .nrst     (NRST),
    .load     (load),
    .tick     (tick),
    .load_val (per_load_val),
    .cnt_r    (per_cnt),
    .zero     (per_zero)
  );

  pfm_down_counter #(
    .W (WIDTH_W)
  ) u_width (
    .clk      (CLK),
    .nrst     (NRST),
    .load     (load),
    .tick     (tick),
    .load_val (wid_load_val),
    .cnt_r    (wid_cnt),
    .zero     (wid_zero)
  );

  ////////////////////////////////////////////////////////////////////////
  // output
  // the pin is high (low with the invert flag) while the width counter runs, so the active time is
  // width ticks; a period of width or less reloads before it ever stops

  always @* begin
    out_nxt = invert_output_flag;
    if (active_r && freq_mod_enable_bit_r) begin
      out_nxt = (!wid_zero) ^ invert_output_flag;
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      FREQ_MOD_OUT <= 1'b0;
    end else begin
      FREQ_MOD_OUT <= out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path
  // control bits 1 and 2 are status only; writing them has no effect
  // reads have no side effect, so polling the status is safe

  always @* begin
    rdata_nxt = 32'h00000000;
    if (addr_hit(WB_ADR_I, `PFM_SETTING_OFS)) begin
      rdata_nxt = freq_mod_setting_r;
    end else if (addr_hit(WB_ADR_I, `PFM_CONTROL_OFS)) begin
      rdata_nxt[`PFM_ENABLE_BIT]   = freq_mod_enable_bit_r;
      rdata_nxt[`PFM_OUT_STAT_BIT] = FREQ_MOD_OUT;
      rdata_nxt[`PFM_ACTIVE_BIT]   = active_r;
    end
  end

  always @* begin
    ack_nxt = bus_req;
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= ack_nxt;
      if (bus_req && !WB_WE_I) begin
        WB_DAT_O <= rdata_nxt;
      end else begin
        WB_DAT_O <= 32'h00000000;
      end
    end
  end

endmodule // pfm_top

// File: verilog/pfm_regs.vh
// pfm_regs.vh: register offsets, field positions and reset values of the
// pulse frequency modulator.
// assumes a 32-bit classic wishbone slave with byte-address offsets.
`ifndef PFM_REGS_VH
`define PFM_REGS_VH

// register byte offsets
`define PFM_SETTING_OFS    4'h0
`define PFM_CONTROL_OFS    4'h4
`define PFM_ADDR_W         4

// setting register fields
`define PFM_PERIOD_LSB     0
`define PFM_PERIOD_MSB     15
`define PFM_WIDTH_LSB      16
`define PFM_WIDTH_MSB      23
`define PFM_INV_BIT        24
`define PFM_WIDTH_BYTE     2
`define PFM_SETTING_RST    32'h00000000
`define PFM_SETTING_MASK   32'h01ffffff

// control register fields
`define PFM_ENABLE_BIT     0
`define PFM_OUT_STAT_BIT   1
`define PFM_ACTIVE_BIT     2

// clock option: divider exponent width
`define PFM_CLKOPT_W       2

`endif

// File: verilog/pfm_down_counter.v
// pfm_down_counter.v: loadable down-counter that halts at zero.
// assumes load and tick come from the same clock domain; load wins.
`timescale 1ns/10ps

module pfm_down_counter #(
  parameter W = 16
) (
  // clock and reset
  input  wire         clk,
  input  wire         nrst,
  // control
  input  wire         load,
  input  wire         tick,
  input  wire [W-1:0] load_val,
  // state
  output reg  [W-1:0] cnt_r,
  output wire         zero
);

  reg [W-1:0] cnt_nxt;

  assign zero = (cnt_r == {W{1'b0}});

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (tick && !zero) begin
      cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= {W{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule // pfm_down_counter

// File: testbench/pfm_props.sv
// pfm_props.sv: port-level assertions for pfm_top.
// assumes one CLK domain with NRST asynchronous and active low.
`timescale 1ns/10ps

module pfm_props (
  // clock and reset
  input wire        CLK,
  input wire        NRST,
  // wishbone slave
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_WE_I,
  input wire [3:0]  WB_ADR_I,
  input wire [3:0]  WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire        WB_ACK_O,
  // option and output
  input wire [1:0]  FREQ_MOD_CLOCK_OPTION,
  input wire        FREQ_MOD_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  wire req    = WB_CYC_I & WB_STB_I & !WB_ACK_O;
  wire rd     = req & !WB_WE_I;
  wire rd_set = rd & (WB_ADR_I == 4'h0);
  wire rd_ctl = rd & (WB_ADR_I == 4'h4);
  wire rd_unm = rd & (WB_ADR_I != 4'h0) & (WB_ADR_I != 4'h4);

  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (req |=> WB_ACK_O)
    else $error("request not acked next cycle");
  a_ack_cause: assert property (WB_ACK_O |-> $past(req))
    else $error("ack without request");
  a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack cycle");
  a_reset_low: assert property ($rose(NRST) |-> (!FREQ_MOD_OUT) [*4])
    else $error("output not low after reset");
  a_unmapped_zero: assert property (WB_ACK_O && $past(rd_unm) |-> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  a_resv_zero: assert property (WB_ACK_O && $past(rd_set) |-> WB_DAT_O[31:25] == 7'h0)
    else $error("reserved setting bits not zero");
  a_ctrl_upper: assert property (WB_ACK_O && $past(rd_ctl) |-> WB_DAT_O[31:3] == 29'h0)
    else $error("upper control bits not zero");
  a_ctrl_status: assert property (
    WB_ACK_O && $past(rd_ctl) |-> WB_DAT_O[1] == $past(FREQ_MOD_OUT))
    else $error("output status bit wrong");
endmodule // pfm_props

bind pfm_top pfm_props u_pfm_props (.CLK, .NRST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
  .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .FREQ_MOD_CLOCK_OPTION, .FREQ_MOD_OUT);

// File: testbench/tb.sv
// tb.sv: self-checking bench for pfm_top.
// assumes setting at 0x0, control at 0x4 and a 20 MHz clock.
`timescale 1ns/10ps

module tb;
  logic        clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, ack, out;
  logic [3:0]  adr = 4'h0, sel = 4'h0, wsel = 4'hf;
  logic [1:0]  opt = 2'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  int          miscompares = 0, n_tests = 0;

  always #25 clk = ~clk;

  pfm_top u_pfm_top (.CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .FREQ_MOD_CLOCK_OPTION(opt), .FREQ_MOD_OUT(out));

  ////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; released only at the edge that sees ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= wsel;
    dat_i <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask

  function automatic logic [31:0] sw(logic iv, logic [7:0] w, logic [15:0] p);
    return {7'h0, iv, w, p};
  endfunction

  // active level is the opposite of the invert flag
  task automatic meas(input logic [31:0] w, p, input logic iv);
    logic [31:0] h, t;
    h = 0;
    do @(negedge clk); while (out !== iv);
    do @(negedge clk); while (out === iv);
    while (out === !iv) begin
      h++;
      @(negedge clk);
    end
    t = h;
    while (out === iv) begin
      t++;
      @(negedge clk);
    end
    chk("high_time", h, w);
    chk("period", t, p);
  endtask

  task automatic steady(input logic v);
    logic [31:0] bad;
    bad = 0;
    repeat (6) @(negedge clk);
    repeat (30) begin
      @(negedge clk);
      if (out !== v) bad++;
    end
    chk("steady", bad, 0);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk("out_rst", out, 0);
    wb(0, 4'h4, 0);
    chk("ctrl_rst", q, 0);
    wb(1, 4'h0, 32'hffffffff);
    wb(0, 4'h0, 0);
    chk("setting", q, 32'h01ffffff);
    wb(1, 4'h8, 32'h12345678);
    wb(0, 4'h8, 0);
    chk("unmapped", q, 0);
  endtask

  task automatic t_run;
    wb(1, 4'h0, sw(0, 3, 8));
    wb(1, 4'h4, 1);
    wb(0, 4'h4, 0);
    chk("ctrl", q & 32'h5, 32'h5);
    meas(3, 8, 0);
    wb(1, 4'h0, sw(1, 2, 5));
    repeat (12) @(negedge clk);
    meas(2, 5, 1);
  endtask

  // byte writes: period alone stays pending until the width byte lands
  task automatic t_bytes;
    @(posedge clk);
    sel <= 4'h1;
    cyc <= 1;
    stb <= 1;
    we <= 1;
    adr <= 4'h0;
    dat_i <= 32'h9;
    do @(posedge clk); while (ack !== 1'b1);
    sel <= 4'h4;
    dat_i <= 32'h00040000;
    cyc <= 0;
    stb <= 0;
    repeat (12) @(negedge clk);
    meas(2, 5, 1);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 0;
    stb <= 0;
    repeat (12) @(negedge clk);
    meas(4, 9, 1);
  endtask

  task automatic t_stop;
    wb(1, 4'h4, 0);
    steady(1);
    wb(0, 4'h0, 0);
    chk("kept", q, 32'h01040009);
    wb(1, 4'h0, sw(0, 0, 5));
    wb(1, 4'h4, 1);
    steady(0);
    wb(1, 4'h4, 0);
    wb(1, 4'h0, sw(0, 6, 4));
    wb(1, 4'h4, 1);
    steady(1);
    wb(1, 4'h0, sw(1, 6, 4));
    steady(0);
    wb(1, 4'h4, 0);
    opt <= 2'h1;
    wb(1, 4'h0, sw(0, 2, 4));
    wb(1, 4'h4, 1);
    meas(4, 8, 0);
    wb(1, 4'h4, 0);
    opt <= 2'h3;
    wb(1, 4'h0, sw(1, 1, 3));
    wb(1, 4'h4, 1);
    meas(8, 24, 1);
  endtask

  // standby byte write: an uncommitted period must not reach the counters
  task automatic t_hold;
    wb(1, 4'h4, 0);
    opt <= 2'h0;
    wsel = 4'h1;
    wb(1, 4'h0, 32'h7);
    wsel = 4'hf;
    wb(1, 4'h4, 1);
    meas(1, 3, 1);
  endtask

  // reset in mid-run, with the output inverted and running
  task automatic t_reset;
    repeat (4) @(negedge clk);
    @(posedge clk);
    nrst <= 0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    @(negedge clk);
    chk("out_rst2", out, 0);
    wb(0, 4'h4, 0);
    chk("ctrl_rst2", q, 0);
    wb(0, 4'h0, 0);
    chk("set_rst2", q, 0);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    t_regs;
    t_run;
    t_bytes;
    t_stop;
    t_hold;
    t_reset;
    wrap_up;
  end

  initial begin
    #(50 * 5000);
    miscompares++;
    wrap_up;
  end
endmodule // tb
